// *** stripe_pkg.sv ***
// Shared constants and carrier types for the stripe track emitter
package stripe_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_NS       = 100;
	localparam int SETUP_NS     = 1000;
	localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_NS    = 20000;
	localparam int STROBE_CYC   = STROBE_NS / CLK_NS;
	localparam int RELEASE_MS   = 150;
	localparam int RELEASE_CYC  = RELEASE_MS * (1000000 / CLK_NS);
	localparam int FLUX_TO_CARD = 14;

	// ==========================================================
	// Character framing
	localparam logic [5:0] START_WIDE  = 6'h05;
	localparam logic [5:0] END_WIDE    = 6'h1f;
	localparam logic [5:0] START_NARROW = 6'h0b;
	localparam logic [5:0] END_NARROW  = 6'h0f;
	localparam logic [3:0] BITS_WIDE   = 4'h7;
	localparam logic [3:0] BITS_NARROW = 4'h5;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_LEAD  = 3'h1,
		S_START = 3'h3,
		S_DATA  = 3'h2,
		S_END   = 3'h6,
		S_CHECK = 3'h7,
		S_TRAIL = 3'h5
	} state_type;

	typedef struct packed {
		logic       last;
		logic [5:0] data;
	} char_type;

	typedef struct packed {
		logic card_n;
		logic data_n;
		logic strobe_n;
	} pins_type;

endpackage

// *** stripe_track_deframer.sv ***
// Reader-side track emitter: frames characters and drives active-low pins
// ==========================================================
// Notes on behaviour
// - Every character carries odd parity.
// - Zeros, start, data, end, check, zeros.
// - Least significant bit first, parity last.
// - Card-detect, data, strobe are active low.
// - Detect after reversals, release after timeout.
// - Data high is zero, low is one.
// - All pins high with no card.
`timescale 1ns/1ns

module stripe_track_deframer #(
	parameter int BIT_CYC     = 952,
	parameter int LEAD_ZEROS  = 16,
	parameter int TRAIL_ZEROS = 16,
	parameter int RELEASE_CNT = stripe_pkg::RELEASE_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 head_clk,
	input  wire logic                 head_rst_n,
	input  wire logic                 flux_in,
	input  wire logic                 narrow_track,
	input  wire logic                 char_valid,
	input  wire stripe_pkg::char_type char_in,
	output logic                      char_ready_r,
	output stripe_pkg::pins_type      pins_r,
	output logic                      busy_r,
	output logic                      underrun_r
);
	import stripe_pkg::*;

	localparam logic [15:0] PH_LAST   = 16'(BIT_CYC - 1);
	localparam logic [15:0] PH_STB    = 16'(SETUP_CYC);
	localparam logic [15:0] PH_STB_UP = 16'(SETUP_CYC + STROBE_CYC);
	localparam logic [7:0]  LEAD_N    = 8'(LEAD_ZEROS - 1);
	localparam logic [7:0]  TRAIL_N   = 8'(TRAIL_ZEROS - 1);
	localparam logic [23:0] REL_LAST  = 24'(RELEASE_CNT - 1);
	localparam logic [3:0]  FLUX_N    = 4'(FLUX_TO_CARD);

	// ==========================================================
	// Head domain: flux reversal events as a toggle
	typedef struct packed {
		logic f1;
		logic f2;
		logic f3;
		logic tgl;
	} head_type;

	head_type h_r;
	head_type h_nxt;

	always_comb begin
		h_nxt = h_r;
		h_nxt.f1 = flux_in;
		h_nxt.f2 = h_r.f1;
		h_nxt.f3 = h_r.f2;
		if (h_r.f2 != h_r.f3) begin
			h_nxt.tgl = ~h_r.tgl;
		end
	end

	always_ff @(posedge head_clk) begin
		if (!head_rst_n) begin
			h_r <= '0;
		end else begin
			h_r <= h_nxt;
		end
	end

	// ==========================================================
	// Main domain state
	typedef struct packed {
		state_type  st;
		logic [15:0] phase;
		logic [6:0] sh;
		logic [3:0] nb;
		logic [7:0] zcnt;
		logic [5:0] column_check_char;
		logic       narrow;
		logic       hold_v;
		char_type   hold;
		logic       last_taken;
		logic       rdy;
		pins_type   pins;
		logic       present;
		logic [3:0] flux_cnt;
		logic [23:0] quiet;
		logic       busy;
		// One frame per card pass; cleared only once card-detect drops
		logic       done;
		logic       underrun;
		logic       s1;
		logic       s2;
		logic       s3;
	} ctl_type;

	ctl_type r;
	ctl_type n;

	function automatic logic [6:0] build(input logic [5:0] d, input logic nar);
		if (nar) begin
			build = {2'b00, ~^d[3:0], d[3:0]};
		end else begin
			build = {~^d, d};
		end
	endfunction

	function automatic logic [3:0] width_of(input logic nar);
		width_of = nar ? BITS_NARROW : BITS_WIDE;
	endfunction

	// Limitation: reversals closer than one main clock merge and undercount
	logic flux_evt;
	assign flux_evt = r.s2 != r.s3;

	always_comb begin
		n = r;
		// Sync stages for the toggle from the head domain
		n.s1 = h_r.tgl;
		n.s2 = r.s1;
		n.s3 = r.s2;

		// ==========================================================
		// Card detect
		// detect after reversals
		if (flux_evt) begin
			n.quiet = '0;
			if (!r.present) begin
				if (r.flux_cnt == FLUX_N - 4'h1) begin
					n.present = 1'b1;
				end else begin
					n.flux_cnt = r.flux_cnt + 4'h1;
				end
			end
		end else if (r.present) begin
			if (r.quiet == REL_LAST) begin
				n.present = 1'b0;
				n.flux_cnt = '0;
				n.quiet = '0;
			end else begin
				n.quiet = r.quiet + 24'h1;
			end
		end

		// ==========================================================
		// Character intake
		if (char_valid && r.rdy) begin
			n.hold_v = 1'b1;
			n.hold = char_in;
		end

		// ==========================================================
		// Bit engine
		if (r.st != S_IDLE) begin
			if (r.phase == 16'h0) begin
				n.pins.data_n = ~r.sh[0];
			end
			if (r.phase == PH_STB) begin
				n.pins.strobe_n = 1'b0;
			end
			if (r.phase == PH_STB_UP) begin
				n.pins.strobe_n = 1'b1;
			end
			if (r.phase == PH_LAST) begin
				n.phase = '0;
				n.sh = r.sh >> 1;
				n.nb = r.nb - 4'h1;
				if (r.nb == 4'h1) begin
					case (r.st)
						S_LEAD: begin
							if (r.zcnt != 8'h0) begin
								n.zcnt = r.zcnt - 8'h1;
								n.sh = '0;
								n.nb = 4'h1;
							end else begin
								n.st = S_START;
								n.column_check_char = r.narrow ? START_NARROW : START_WIDE;
								n.sh = build(n.column_check_char, r.narrow);
								n.nb = width_of(r.narrow);
							end
						end
						S_START, S_DATA: begin
							if (r.hold_v && !r.last_taken) begin
								n.st = S_DATA;
								n.hold_v = 1'b0;
								n.last_taken = r.hold.last;
								n.column_check_char = r.column_check_char ^ r.hold.data;
								n.sh = build(r.hold.data, r.narrow);
								n.nb = width_of(r.narrow);
							end else begin
								// Starved host still gets a well formed track
								n.underrun = ~r.last_taken;
								n.st = S_END;
								n.column_check_char = r.column_check_char ^ (r.narrow ? END_NARROW : END_WIDE);
								n.sh = build(r.narrow ? END_NARROW : END_WIDE, r.narrow);
								n.nb = width_of(r.narrow);
							end
						end
						S_END: begin
							n.st = S_CHECK;
							n.sh = build(r.column_check_char, r.narrow);
							n.nb = width_of(r.narrow);
						end
						S_CHECK: begin
							n.st = S_TRAIL;
							n.zcnt = TRAIL_N;
							n.sh = '0;
							n.nb = 4'h1;
						end
						S_TRAIL: begin
							if (r.zcnt != 8'h0) begin
								n.zcnt = r.zcnt - 8'h1;
								n.sh = '0;
								n.nb = 4'h1;
							end else begin
								n.st = S_IDLE;
								n.busy = 1'b0;
							end
						end
						default: begin
							n.st = S_IDLE;
						end
					endcase
				end
			end else begin
				n.phase = r.phase + 16'h1;
			end
		end else if (r.present && !r.done) begin
			n.st = S_LEAD;
			n.busy = 1'b1;
			n.done = 1'b1;
			n.underrun = 1'b0;
			// Width and parity mode latch once per frame
			n.narrow = narrow_track;
			n.last_taken = 1'b0;
			n.hold_v = 1'b0;
			n.phase = '0;
			n.zcnt = LEAD_N;
			n.sh = '0;
			n.nb = 4'h1;
		end else if (!r.present) begin
			n.busy = 1'b0;
			n.done = 1'b0;
		end

		if (!n.present) begin
			n.st = S_IDLE;
			n.pins.data_n = 1'b1;
			n.pins.strobe_n = 1'b1;
		end
		n.pins.card_n = ~n.present;
		n.rdy = (n.st == S_LEAD || n.st == S_START || n.st == S_DATA) && !n.hold_v && !n.last_taken;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// Pins idle high out of reset so the host sees no card
			r <= '{st: S_IDLE, pins: '{card_n: 1'b1, data_n: 1'b1, strobe_n: 1'b1}, default: '0};
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// Outputs
	assign char_ready_r = r.rdy;
	assign pins_r       = r.pins;
	assign busy_r       = r.busy;
	assign underrun_r   = r.underrun;

endmodule

// *** stripe_track_deframer_assertions.sv ***
// Checker for the emitted track pins and host handshake
`timescale 1ns/1ns
module stripe_track_deframer_assertions (
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire logic                 char_valid,
	input wire logic                 char_ready_r,
	input wire stripe_pkg::pins_type pins_r,
	input wire logic                 busy_r,
	input wire logic                 underrun_r
);
	import stripe_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Pin relations
	a_idle_pins_high: assert property (pins_r.card_n |-> pins_r.data_n && pins_r.strobe_n)
		else $error("data or strobe low without card");
	a_strobe_in_frame: assert property (!pins_r.strobe_n |-> busy_r)
		else $error("strobe outside frame");
	a_frame_follows_card: assert property ($fell(pins_r.card_n) |=> $rose(busy_r))
		else $error("frame did not follow card detect");
	a_data_setup: assert property ($fell(pins_r.strobe_n) |-> $past(pins_r.data_n, 9) == pins_r.data_n)
		else $error("data changed too close to strobe");
	a_data_held: assert property (!pins_r.strobe_n && !$past(pins_r.strobe_n) |-> $stable(pins_r.data_n))
		else $error("data moved under strobe");
	a_bit_spacing: assert property ($fell(pins_r.strobe_n) |=> (!$fell(pins_r.strobe_n)) [*8])
		else $error("strobes too close");
	// ==========================================================
	// Host side
	a_take_drops_ready: assert property (char_valid && char_ready_r |=> !char_ready_r)
		else $error("ready stayed high after take");
	a_underrun_in_frame: assert property ($rose(underrun_r) |-> busy_r)
		else $error("underrun outside frame");
	c_frame: cover property ($rose(busy_r));
	c_take: cover property (char_valid && char_ready_r);
	c_underrun: cover property ($rose(underrun_r));
endmodule
bind stripe_track_deframer stripe_track_deframer_assertions u_chk (.clk(clk), .rst_n(rst_n),
	.char_valid(char_valid), .char_ready_r(char_ready_r), .pins_r(pins_r), .busy_r(busy_r),
	.underrun_r(underrun_r));

// *** stripe_receiver_model.sv ***
// Receiver model: captures the emitted track bits
`timescale 1ns/1ns
module stripe_receiver_model (
	input wire stripe_pkg::pins_type pins
);
	import stripe_pkg::*;
	// raw bits kept for either direction
	logic bits[$];
	// ==========================================================
	// strobe clocks data
	always @(negedge pins.strobe_n) begin
		if (pins.card_n === 1'b0) begin
			bits.push_back(~pins.data_n);
		end
	end
	always @(negedge pins.card_n) begin
		bits.delete();
	end
endmodule

// *** testbench.sv ***
// Testbench: sends track frames and checks the pin stream
`timescale 1ns/1ns
module testbench;
	import stripe_pkg::*;
	localparam int LZ = 4;
	logic     clk, rst_n, head_clk, head_rst_n, flux_in, narrow_track, char_valid, char_ready_r, busy_r, underrun_r;
	char_type char_in;
	pins_type pins_r;
	int       num_errors, total_checks, cycles;
	logic     exp_q[$];
	logic [5:0] chk_acc;
	logic [5:0] dat[3];
	localparam logic [7:0] ASC_WIDE   = 8'h20;
	localparam logic [7:0] ASC_NARROW = 8'h30;
	logic [7:0] txt[3];
	logic [7:0] rx_txt[8];
	int         rx_n;
	stripe_track_deframer #(.BIT_CYC(240), .LEAD_ZEROS(LZ), .TRAIL_ZEROS(LZ), .RELEASE_CNT(16000)) DUT (
		.clk(clk), .rst_n(rst_n), .head_clk(head_clk), .head_rst_n(head_rst_n), .flux_in(flux_in),
		.narrow_track(narrow_track), .char_valid(char_valid), .char_in(char_in),
		.char_ready_r(char_ready_r), .pins_r(pins_r), .busy_r(busy_r), .underrun_r(underrun_r));
	stripe_receiver_model RX (.pins(pins_r));
	// ==========================================================
	// Clocks and watchdog
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	initial begin
		head_clk = 0;
		#7;
		forever #16 head_clk = ~head_clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			complete_run();
		end
	end
	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic add_char(input logic [5:0] v, input int w);
		logic p;
		p = 1'b1;
		for (int i = 0; i < w; i++) begin
			exp_q.push_back(v[i]);
			p ^= v[i];
			chk_acc[i] ^= v[i];
		end
		exp_q.push_back(p);
	endtask
	task automatic send(input logic [5:0] v, input logic lst);
		@(posedge clk);
		char_in <= {lst, v};
		char_valid <= 1'b1;
		do @(posedge clk); while (char_ready_r !== 1'b1);
		char_valid <= 1'b0;
	endtask
	function automatic logic got_bit(input int i, input logic flip);
		int k;
		k = flip ? RX.bits.size() - 1 - i : i;
		got_bit = (k >= 0 && k < RX.bits.size()) ? RX.bits[k] : 1'b0;
	endfunction
	function automatic logic [6:0] get_char(input int at, input int w, input logic flip);
		get_char = '0;
		for (int b = 0; b <= w; b++) get_char[b] = got_bit(at + b, flip);
	endfunction
	function automatic logic [6:0] enc(input logic [5:0] v, input int w);
		enc = '0;
		for (int b = 0; b < w; b++) enc[b] = v[b];
		// Odd parity sits just above the data bits
		enc[w] = ~^enc;
	endfunction
	task automatic decode(input logic nar, input logic back, output logic ok);
		int w;
		int at;
		int k;
		logic flip;
		logic [6:0] c;
		logic [6:0] mark;
		logic [6:0] stop;
		logic [5:0] acc;
		ok = 1'b0;
		w = nar ? 4 : 6;
		mark = enc(nar ? START_NARROW : START_WIDE, w);
		stop = enc(nar ? END_NARROW : END_WIDE, w);
		for (int dir = 0; dir < 2 && !ok; dir++) begin
			flip = (dir == 0) ? back : ~back;
			at = 0;
			for (int s = 0; s + 5 + w <= RX.bits.size() && !ok; s++) begin
				// four zeros then start marker, next char not the end marker
				if (get_char(s, 3, flip) == 7'h00 && get_char(s + 4, w, flip) == mark &&
						get_char(s + 5 + w, w, flip) != stop) begin
					ok = 1'b1;
					at = s + 4;
				end
			end
			acc = '0;
			c = '0;
			k = 0;
			rx_n = 0;
			// collect up to the end marker
			while (ok && c != stop) begin
				c = get_char(at, w, flip);
				at += w + 1;
				if (!(^c) || at > RX.bits.size()) ok = 1'b0;
				for (int b = 0; b < w; b++) acc[b] ^= c[b];
				if (k > 0 && c != stop && rx_n < 8) begin
					rx_txt[rx_n] = nar ? {4'h0, c[3:0]} + ASC_NARROW : {2'b00, c[5:0]} + ASC_WIDE;
					rx_n++;
				end
				k++;
			end
			c = get_char(at, w, flip);
			if (!(^c)) ok = 1'b0;
			for (int b = 0; b < w; b++) if (c[b] != acc[b]) ok = 1'b0;
		end
	endtask
	task automatic run_frame(input logic nar, input int n, input logic under);
		int w;
		logic ok;
		w = nar ? 4 : 6;
		exp_q.delete();
		chk_acc = '0;
		for (int i = 0; i < LZ; i++) exp_q.push_back(1'b0);
		add_char(nar ? START_NARROW : START_WIDE, w);
		for (int i = 0; i < n; i++) add_char(dat[i], w);
		add_char(nar ? END_NARROW : END_WIDE, w);
		add_char(chk_acc, w);
		for (int i = 0; i < LZ; i++) exp_q.push_back(1'b0);
		@(posedge clk);
		narrow_track <= nar;
		repeat (14) begin
			repeat (8) @(posedge head_clk);
			flux_in <= ~flux_in;
		end
		for (int i = 0; i < n; i++) send(dat[i], i == n - 1);
		do @(posedge clk); while (pins_r.card_n !== 1'b0);
		do @(posedge clk); while (pins_r.card_n !== 1'b1);
		check(RX.bits.size(), exp_q.size());
		for (int i = 0; i < exp_q.size(); i++) check(RX.bits[i], exp_q[i]);
		check(underrun_r, under);
		check(busy_r, 1'b0);
		if (n > 0) begin
			decode(nar, 1'b0, ok);
			check(ok, 1'b1);
			decode(nar, 1'b1, ok);
			check(ok, 1'b1);
			check(rx_n, n);
			for (int i = 0; i < n; i++) check(rx_txt[i], txt[i]);
		end
		$display("frame test done at %0t", $time);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		{rst_n, head_rst_n, flux_in, narrow_track, char_valid} = '0;
		char_in = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		head_rst_n <= 1'b1;
		txt = '{8'h20, 8'h5f, 8'h45};
		// encode by taking off the offset
		foreach (txt[i]) dat[i] = 6'(txt[i] - ASC_WIDE);
		run_frame(1'b0, 3, 1'b0);
		txt = '{8'h30, 8'h39, 8'h3d};
		// encode by taking off the offset
		foreach (txt[i]) dat[i] = 6'(txt[i] - ASC_NARROW);
		run_frame(1'b1, 3, 1'b0);
		run_frame(1'b1, 0, 1'b1);
		complete_run();
	end
endmodule
